//--- load_shift_exec.sv
// load and shift execution behind an AHB-Lite register window
// ==========================================================
// Functional notes
// (RULE1) halfword load, zero-extended to target
// (RULE2) byte load, sign-extended to target
// (RULE3) halfword load, sign-extended to target
// (RULE4) address is base plus unshifted offset, no writeback
// (RULE5) immediate left shift, zeros in
// (RULE6) immediate left shift by zero is a move
// (RULE7) immediate right shift by 1 to 32, zeros in
// (RULE8) register-amount left shift, zeros in
// (RULE9) register-amount right shift, zeros in
// (RULE10) count is amount register bits 7:0, unsigned
// (RULE11) one field is operand and destination
// (RULE12) N bit 31, Z zero, C carry-out, V kept
// (RULE13) flags kept inside a conditional block; the code still updates N and Z for a move (left shift by zero)
// (RULE14) register left shift has top bits 0100000010
// (RULE15) count 32 or more gives zero; edge carry at 32
// (RULE16) load error: hard fault, target unwritten
// (RULE17) right shift amount zero means 32
//
// Local design decisions: the address map and the AHB-Lite slave port.
module load_shift_exec (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // data load port
   output logic             mem_req,
   output logic      [31:0] mem_addr,
   output logic      [1:0]  mem_size,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_ready,
   input  wire logic        mem_err,
   // events
   output logic             hard_fault_exception,
   output logic             irq
);

   // ==========================================================
   // bus slave
   logic        addr_phase;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic        rd_pend_q;
   logic        rd_fin_q;
   logic [7:0]  rd_addr_q;
   logic [31:0] rd_mux;
   // hsize ignored: word transfers only
   assign addr_phase = hsel && htrans[1] && hready;
   // reads take two wait states so a write just before is always seen
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_pend_q <= 1'b0;
         rd_fin_q  <= 1'b0;
         rd_addr_q <= 8'h00;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
      end else if (ce) begin
         wr_pend_q <= addr_phase && hwrite;
         rd_pend_q <= addr_phase && !hwrite;
         rd_fin_q  <= rd_pend_q;
         if (addr_phase) begin
            wr_addr_q <= haddr[7:0];
            rd_addr_q <= haddr[7:0];
         end
         if (addr_phase && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_fin_q) begin
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
         end
      end
   end
   assign hresp = 1'b0;

   // ==========================================================
   // write decode
   logic       wr_ctrl;
   logic       wr_instr;
   logic       wr_flags;
   logic       wr_irq_clr;
   logic       wr_irq_en;
   logic       wr_gpr;
   logic       rd_is_gpr;
   assign wr_ctrl    = wr_pend_q && (wr_addr_q == load_shift_pkg::OFS_CTRL);
   assign wr_instr   = wr_pend_q && (wr_addr_q == load_shift_pkg::OFS_INSTR);
   assign wr_flags   = wr_pend_q && (wr_addr_q == load_shift_pkg::OFS_FLAGS);
   assign wr_irq_clr = wr_pend_q && (wr_addr_q == load_shift_pkg::OFS_IRQ_CLEAR);
   assign wr_irq_en  = wr_pend_q && (wr_addr_q == load_shift_pkg::OFS_IRQ_ENABLE);
   assign wr_gpr     = wr_pend_q && (wr_addr_q[7:5] == load_shift_pkg::GPR_PAGE);
   assign rd_is_gpr  = rd_addr_q[7:5] == load_shift_pkg::GPR_PAGE;

   // ==========================================================
   // control, flags and instruction registers
   logic                   cond_block_q;
   logic [3:0]             flags_q;
   logic [3:0]             flags_d;
   logic [15:0]            instr_q;
   load_shift_pkg::op_t    op_q;
   load_shift_pkg::op_t    op_in;
   load_shift_pkg::state_t state_q;
   logic [31:0]            opa_q;
   logic [31:0]            fault_addr_q;
   logic                   busy;
   logic                   issue;
   assign busy  = state_q != load_shift_pkg::ST_IDLE;
   assign issue = wr_instr && !busy;

   // ==========================================================
   // instruction decode
   always_comb begin
      if (hwdata[15:9] == load_shift_pkg::OPC_LOAD_HZ) begin
         op_in = load_shift_pkg::OP_LD_HZ;
      end else if (hwdata[15:9] == load_shift_pkg::OPC_LOAD_BS) begin
         op_in = load_shift_pkg::OP_LD_BS;
      end else if (hwdata[15:9] == load_shift_pkg::OPC_LOAD_HS) begin
         op_in = load_shift_pkg::OP_LD_HS;
      end else if (hwdata[15:11] == load_shift_pkg::OPC_LSL_IMM) begin
         op_in = (hwdata[10:6] == 5'h00) ? load_shift_pkg::OP_MOVE    // [RULE6]
                                         : load_shift_pkg::OP_LSL_IMM;
      end else if (hwdata[15:11] == load_shift_pkg::OPC_LSR_IMM) begin
         op_in = load_shift_pkg::OP_LSR_IMM;
      end else if (hwdata[15:6] == load_shift_pkg::OPC_LSL_REG) begin
         op_in = load_shift_pkg::OP_LSL_REG;                          // [RULE14]
      end else if (hwdata[15:6] == load_shift_pkg::OPC_LSR_REG) begin
         op_in = load_shift_pkg::OP_LSR_REG;
      end else begin
         op_in = load_shift_pkg::OP_NONE;
      end
   end

   // ==========================================================
   // operand fields
   logic        is_load;
   logic        is_reg_shift;
   logic        is_right;
   logic [2:0]  f_low;
   logic [2:0]  f_mid;
   logic [2:0]  f_high;
   logic [4:0]  f_amount;
   logic [2:0]  rf_raddr_a;
   logic [31:0] rf_rdata_a;
   logic [31:0] rf_rdata_b;
   assign f_low    = instr_q[2:0];
   assign f_mid    = instr_q[5:3];
   assign f_high   = instr_q[8:6];
   assign f_amount = instr_q[10:6];
   assign is_load      = (op_q == load_shift_pkg::OP_LD_HZ) ||
                         (op_q == load_shift_pkg::OP_LD_BS) ||
                         (op_q == load_shift_pkg::OP_LD_HS);
   assign is_reg_shift = (op_q == load_shift_pkg::OP_LSL_REG) ||
                         (op_q == load_shift_pkg::OP_LSR_REG);
   assign is_right     = (op_q == load_shift_pkg::OP_LSR_IMM) ||
                         (op_q == load_shift_pkg::OP_LSR_REG);
   // first read: base or operand; second: offset or count
   assign rf_raddr_a = (state_q == load_shift_pkg::ST_RD_FIRST) ?
                       (is_reg_shift ? f_low : f_mid) :                   // [RULE11]
                       (is_load ? f_high : f_mid);

   // ==========================================================
   // shifter
   logic [7:0]  shift_amount;
   logic [31:0] shift_result;
   logic        shift_carry;
   always_comb begin
      if (is_reg_shift) begin
         shift_amount = rf_rdata_a[7:0];                                  // [RULE10]
      end else if (op_q == load_shift_pkg::OP_LSR_IMM && f_amount == 5'h00) begin
         shift_amount = load_shift_pkg::SHIFT_BY_32;                      // [RULE17]
      end else if (op_q == load_shift_pkg::OP_MOVE) begin
         shift_amount = 8'h00;
      end else begin
         shift_amount = {3'h0, f_amount};                                 // [RULE5] [RULE7]
      end
   end

   shift_unit u_shift (
      .value     (opa_q),
      .amount    (shift_amount),
      .right     (is_right),                                              // [RULE8] [RULE9]
      .carry_in  (flags_q[load_shift_pkg::FLAG_C]),
      .result    (shift_result),
      .carry_out (shift_carry)
   );

   // ==========================================================
   // load data extension and register write-back
   logic        exec_cycle;
   logic        load_ok;
   logic        shift_wb;
   logic [31:0] load_data;
   logic        rf_we;
   logic [2:0]  rf_waddr;
   logic [31:0] rf_wdata;
   always_comb begin
      if (op_q == load_shift_pkg::OP_LD_BS) begin
         load_data = {{24{mem_rdata[7]}}, mem_rdata[7:0]};                // [RULE2]
      end else if (op_q == load_shift_pkg::OP_LD_HS) begin
         load_data = {{16{mem_rdata[15]}}, mem_rdata[15:0]};              // [RULE3]
      end else begin
         load_data = {16'h0, mem_rdata[15:0]};                            // [RULE1]
      end
   end

   assign exec_cycle = state_q == load_shift_pkg::ST_EXEC_MEM;
   assign load_ok    = exec_cycle && mem_req && mem_ready && !mem_err;    // [RULE16]
   assign shift_wb   = exec_cycle && !is_load;
   assign rf_we      = load_ok || shift_wb || (wr_gpr && !busy);
   assign rf_waddr   = busy ? f_low : wr_addr_q[4:2];
   assign rf_wdata   = load_ok ? load_data : (shift_wb ? shift_result : hwdata);
   reg_file #(.DEPTH(8), .WIDTH(32), .AW(3)) u_regs (
      .clk     (clk),
      .resetn  (resetn),
      .ce      (ce),
      .we      (rf_we),
      .waddr   (rf_waddr),
      .wdata   (rf_wdata),
      .raddr_a (rf_raddr_a),
      .rdata_a (rf_rdata_a),
      .raddr_b (rd_addr_q[4:2]),
      .rdata_b (rf_rdata_b)
   );

   // ==========================================================
   // flags
   always_comb begin
      flags_d = flags_q;
      if (shift_wb && op_q == load_shift_pkg::OP_MOVE) begin
         flags_d[load_shift_pkg::FLAG_N] = shift_result[31];
         flags_d[load_shift_pkg::FLAG_Z] = shift_result == 32'h0;
      end else if (shift_wb && !cond_block_q) begin                      // [RULE13]
         flags_d[load_shift_pkg::FLAG_N] = shift_result[31];              // [RULE12]
         flags_d[load_shift_pkg::FLAG_Z] = shift_result == 32'h0;
         flags_d[load_shift_pkg::FLAG_C] = shift_carry;
      end else if (wr_flags) begin
         flags_d = hwdata[load_shift_pkg::FLAG_LSB +: 4];
      end
   end

   // ==========================================================
   // sequencer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q      <= load_shift_pkg::ST_IDLE;
         op_q         <= load_shift_pkg::OP_NONE;
         instr_q      <= 16'h0;
         opa_q        <= 32'h0;
         mem_req      <= 1'b0;
         mem_addr     <= 32'h0;
         mem_size     <= load_shift_pkg::SIZE_BYTE;
         fault_addr_q <= 32'h0;
      end else if (ce) begin
         case (state_q)
            load_shift_pkg::ST_IDLE: begin
               if (issue && op_in != load_shift_pkg::OP_NONE) begin
                  instr_q <= hwdata[15:0];
                  op_q    <= op_in;
                  state_q <= load_shift_pkg::ST_RD_FIRST;
               end
            end
            load_shift_pkg::ST_RD_FIRST: begin
               state_q <= load_shift_pkg::ST_RD_SECOND;
            end
            load_shift_pkg::ST_RD_SECOND: begin
               opa_q   <= rf_rdata_a;
               state_q <= load_shift_pkg::ST_EXEC_MEM;
            end
            load_shift_pkg::ST_EXEC_MEM: begin
               if (!is_load) begin
                  state_q <= load_shift_pkg::ST_IDLE;
               end else if (!mem_req) begin
                  mem_addr <= opa_q + rf_rdata_a;                         // [RULE4]
                  mem_size <= (op_q == load_shift_pkg::OP_LD_BS) ?
                              load_shift_pkg::SIZE_BYTE : load_shift_pkg::SIZE_HALF;
                  mem_req  <= 1'b1;
               end else if (mem_ready) begin
                  mem_req <= 1'b0;
                  state_q <= load_shift_pkg::ST_IDLE;
                  if (mem_err) begin
                     fault_addr_q <= mem_addr;                            // [RULE16]
                  end
               end
            end
            default: begin
               state_q <= load_shift_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // events and interrupt
   logic [load_shift_pkg::IRQ_W-1:0] irq_evt;
   logic [load_shift_pkg::IRQ_W-1:0] irq_clr;
   logic [load_shift_pkg::IRQ_W-1:0] irq_stat_q;
   logic [load_shift_pkg::IRQ_W-1:0] irq_stat_d;
   logic [load_shift_pkg::IRQ_W-1:0] irq_en_q;
   logic                             fault_evt;
   assign fault_evt = exec_cycle && mem_req && mem_ready && mem_err;      // [RULE16]
   assign irq_evt[load_shift_pkg::IRQ_DONE]  = load_ok || shift_wb;
   assign irq_evt[load_shift_pkg::IRQ_FAULT] = fault_evt;
   assign irq_evt[load_shift_pkg::IRQ_UNDEF] = issue && op_in == load_shift_pkg::OP_NONE;
   assign irq_clr    = wr_irq_clr ? hwdata[load_shift_pkg::IRQ_W-1:0] : '0;
   // an event wins over a same-cycle clear
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cond_block_q         <= 1'b0;
         flags_q              <= load_shift_pkg::FLAGS_RESET;
         irq_stat_q           <= '0;
         irq_en_q             <= load_shift_pkg::IRQ_EN_RESET;
         hard_fault_exception <= 1'b0;
         irq                  <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl) begin
            cond_block_q <= hwdata[load_shift_pkg::CTRL_COND_BIT];
         end
         if (wr_irq_en) begin
            irq_en_q <= hwdata[load_shift_pkg::IRQ_W-1:0];
         end
         flags_q              <= flags_d;
         irq_stat_q           <= irq_stat_d;
         hard_fault_exception <= fault_evt;
         irq <= |(irq_stat_d & (wr_irq_en ? hwdata[load_shift_pkg::IRQ_W-1:0] : irq_en_q));
      end
   end

   // ==========================================================
   // read mux
   always_comb begin
      if (rd_addr_q == load_shift_pkg::OFS_CTRL) begin
         rd_mux = {31'h0, cond_block_q};
      end else if (rd_addr_q == load_shift_pkg::OFS_INSTR) begin
         rd_mux = {16'h0, instr_q};
      end else if (rd_addr_q == load_shift_pkg::OFS_STATUS) begin
         rd_mux = {31'h0, busy};
      end else if (rd_addr_q == load_shift_pkg::OFS_FLAGS) begin
         rd_mux = {flags_q, 28'h0};
      end else if (rd_addr_q == load_shift_pkg::OFS_IRQ_STATUS) begin
         rd_mux = {29'h0, irq_stat_q};
      end else if (rd_addr_q == load_shift_pkg::OFS_IRQ_ENABLE) begin
         rd_mux = {29'h0, irq_en_q};
      end else if (rd_addr_q == load_shift_pkg::OFS_FAULT_ADDR) begin
         rd_mux = fault_addr_q;
      end else if (rd_is_gpr) begin
         rd_mux = rf_rdata_b;
      end else begin
         rd_mux = 32'h0;
      end
   end

endmodule : load_shift_exec

//--- load_shift_exec_props.sv
// assertions on the ports of the load and shift execution block
module load_shift_exec_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // register bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // load port and events
   input wire logic        mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0]  mem_size,
   input wire logic        mem_ready,
   input wire logic        mem_err,
   input wire logic        hard_fault_exception
);
   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire done_m = mem_req && mem_ready;
   wire flt_m  = done_m && mem_err;
   wire rd_m   = hsel && htrans[1] && hready && !hwrite;
   property p_fault_pulse; flt_m |=> hard_fault_exception ##1 !hard_fault_exception; endproperty
   a_fault_pulse: assert property (p_fault_pulse) else $error("no fault pulse");
   property p_fault_cause; hard_fault_exception |-> $past(flt_m); endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("stray fault");
   property p_no_fault; done_m && !mem_err |=> !hard_fault_exception; endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault on good load");
   property p_req_hold; mem_req && !mem_ready |=> mem_req && $stable(mem_addr); endproperty
   a_req_hold: assert property (p_req_hold) else $error("load request moved");
   property p_req_drop; done_m |=> !mem_req [*2]; endproperty
   a_req_drop: assert property (p_req_drop) else $error("load repeated");
   property p_size; mem_req |-> mem_size inside {2'h0, 2'h1}; endproperty
   a_size: assert property (p_size) else $error("bad load size");
   property p_rd_wait; rd_m |=> !hreadyout [*2] ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   c_fault: cover property (flt_m);
   c_load: cover property (done_m && !mem_err);
   c_read: cover property (rd_m);
endmodule : load_shift_exec_props

//--- load_shift_exec_tb_top.sv
// self-checking bench for the load and shift execution block
module load_shift_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [15:0] i; logic [31:0] a, b, r; logic [3:0] f;} case_t;
   logic        clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, err = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, ldata = 32'h0, rd, cap_a;
   logic [1:0]  htrans = 2'h0, cap_s;
   logic [3:0]  lat = 4'h0;
   logic [31:0] hrdata, mem_addr, mem_rdata;
   logic [1:0]  mem_size;
   logic        hreadyout, hresp, mem_req, mem_ready, mem_err, hfe, irq;
   int          num_errors = 0, total_checks = 0, cycles = 0, nf = 0;
   case_t cs [8] = '{
      '{16'h010A, 32'h1800_000F, 32'h0, 32'h8000_00F0, 4'hB},
      '{16'h000A, 32'h1800_000F, 32'h0, 32'h1800_000F, 4'h3},
      '{16'h080A, 32'h7FFF_FFFF, 32'h0, 32'h0, 4'h5},
      '{16'h084A, 32'h8000_0002, 32'h0, 32'h4000_0001, 4'h1},
      '{16'h408A, 32'h0000_0120, 32'h1, 32'h0, 4'h7},
      '{16'h40CA, 32'h0000_0021, 32'hFFFF_FFFF, 32'h0, 4'h5},
      '{16'h40CA, 32'h0000_0004, 32'h8000_0010, 32'h0800_0001, 4'h1},
      '{16'h408A, 32'h0000_FF00, 32'h8000_0000, 32'h8000_0000, 4'hB}};
   always #50 clk = ~clk;
   load_shift_exec load_shift_exec_i (.clk(clk), .resetn(resetn), .ce(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size), .mem_rdata(mem_rdata),
      .mem_ready(mem_ready), .mem_err(mem_err), .hard_fault_exception(hfe), .irq(irq));
   mem_model mem_model_i (.clk(clk), .req(mem_req), .lat(lat), .err(err), .data(ldata),
      .rdata(mem_rdata), .ready(mem_ready), .eflag(mem_err));
   // ==========================================================
   // bus and check helpers
   always @(posedge clk) begin
      cycles++;
      if (hfe) nf++;
      if (mem_req && mem_ready) begin
         cap_a = mem_addr;
         cap_s = mem_size;
      end
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // master holds each phase until hready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   function automatic logic [7:0] gpr(input logic [2:0] i);
      return {load_shift_pkg::GPR_PAGE, i, 2'h0};
   endfunction : gpr
   task automatic run(input logic [15:0] ins);
      bus(1'b1, load_shift_pkg::OFS_INSTR, {16'h0, ins});
      do bus(1'b0, load_shift_pkg::OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
   endtask : run
   // ==========================================================
   // scenarios
   task automatic t_load(input logic [6:0] opc, input logic [1:0] sz, input logic [31:0] e);
      bus(1'b1, gpr(3'h1), 32'h1000_0003);
      bus(1'b1, gpr(3'h2), 32'h0000_0101);
      lat <= lat + 4'h1;
      run({opc, 9'h08B});
      chk("ld_addr", 32'h1000_0104, cap_a);
      chk("ld_size", {30'h0, sz}, {30'h0, cap_s});
      bus(1'b0, gpr(3'h3), 32'h0);
      chk("ld_data", e, rd);
      bus(1'b0, gpr(3'h1), 32'h0);
      chk("ld_base", 32'h1000_0003, rd);
      $display("load test done");
   endtask : t_load
   task automatic t_fault();
      bus(1'b1, gpr(3'h3), 32'h5555_AAAA);
      bus(1'b1, load_shift_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
      nf = 0;
      err <= 1'b1;
      run({load_shift_pkg::OPC_LOAD_BS, 9'h08B});
      err <= 1'b0;
      chk("pulses", 32'h1, nf);
      bus(1'b0, gpr(3'h3), 32'h0);
      chk("ld_kept", 32'h5555_AAAA, rd);
      bus(1'b0, load_shift_pkg::OFS_FAULT_ADDR, 32'h0);
      chk("fault_addr", 32'h1000_0104, rd);
      run(16'hFFFF);
      bus(1'b0, load_shift_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("irq_status", 32'h6, rd);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'b1, load_shift_pkg::OFS_IRQ_ENABLE, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      bus(1'b1, load_shift_pkg::OFS_IRQ_CLEAR, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk("irq_off", 32'h0, {31'h0, irq});
      $display("fault test done");
   endtask : t_fault
   task automatic t_shift(input case_t c, input logic cond);
      bus(1'b1, load_shift_pkg::OFS_CTRL, {31'h0, cond});
      bus(1'b1, load_shift_pkg::OFS_FLAGS, 32'h3000_0000);
      bus(1'b1, gpr(3'h1), c.a);
      bus(1'b1, gpr(3'h2), c.b);
      run(c.i);
      bus(1'b0, gpr(3'h2), 32'h0);
      chk("shift_res", c.r, rd);
      bus(1'b0, load_shift_pkg::OFS_FLAGS, 32'h0);
      chk("flags", {28'h0, cond ? 4'h3 : c.f}, {28'h0, rd[31:28]});
   endtask : t_shift
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      ldata <= 32'hABCD_F08C;
      bus(1'b0, load_shift_pkg::OFS_FLAGS, 32'h0);
      chk("flags_rst", 32'h0, rd);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      t_load(load_shift_pkg::OPC_LOAD_HZ, 2'h1, 32'h0000_F08C);
      t_load(load_shift_pkg::OPC_LOAD_BS, 2'h0, 32'hFFFF_FF8C);
      t_load(load_shift_pkg::OPC_LOAD_HS, 2'h1, 32'hFFFF_F08C);
      t_fault();
      foreach (cs[k]) t_shift(cs[k], 1'b0);
      t_shift(cs[0], 1'b1);
      $display("shift test done");
      close_out();
   end
endmodule : load_shift_exec_tb_top

bind load_shift_exec load_shift_exec_props load_shift_exec_props_i (
   .clk(clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_size(mem_size), .mem_ready(mem_ready),
   .mem_err(mem_err), .hard_fault_exception(hard_fault_exception));

//--- load_shift_pkg.sv
// shared constants and types of the load and shift block
package load_shift_pkg;

   // ==========================================================
   // register map (byte offsets in an 8-bit window)
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_INSTR      = 8'h04;
   localparam logic [7:0] OFS_STATUS     = 8'h08;
   localparam logic [7:0] OFS_FLAGS      = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] OFS_FAULT_ADDR = 8'h1C;
   localparam logic [2:0] GPR_PAGE       = 3'h1;

   // ==========================================================
   // field positions
   localparam int CTRL_COND_BIT   = 0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int FLAG_LSB        = 28;
   localparam int FLAG_N          = 3;
   localparam int FLAG_Z          = 2;
   localparam int FLAG_C          = 1;
   localparam int IRQ_DONE        = 0;
   localparam int IRQ_FAULT       = 1;
   localparam int IRQ_UNDEF       = 2;
   localparam int IRQ_W           = 3;

   // ==========================================================
   // reset values
   localparam logic [3:0]       FLAGS_RESET  = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

   // ==========================================================
   // opcode patterns
   localparam logic [6:0] OPC_LOAD_HZ   = 7'h2D;
   localparam logic [6:0] OPC_LOAD_BS   = 7'h2B;
   localparam logic [6:0] OPC_LOAD_HS   = 7'h2F;
   localparam logic [4:0] OPC_LSL_IMM   = 5'h00;
   localparam logic [4:0] OPC_LSR_IMM   = 5'h01;
   localparam logic [9:0] OPC_LSL_REG   = 10'h102;
   localparam logic [9:0] OPC_LSR_REG   = 10'h103;
   localparam logic [7:0] SHIFT_BY_32   = 8'h20;

   // ==========================================================
   // memory access sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;

   typedef enum logic [1:0] {ST_IDLE, ST_RD_FIRST, ST_RD_SECOND, ST_EXEC_MEM} state_t;

   typedef enum logic [3:0] {
      OP_NONE, OP_LD_HZ, OP_LD_BS, OP_LD_HS, OP_LSL_IMM, OP_LSR_IMM,
      OP_LSL_REG, OP_LSR_REG, OP_MOVE
   } op_t;

endpackage : load_shift_pkg

//--- mem_model.sv
// memory answering data loads after a chosen number of cycles
module mem_model (
   // clock and request
   input wire logic        clk,
   input wire logic        req,
   input wire logic [3:0]  lat,
   input wire logic        err,
   input wire logic [31:0] data,
   // answer
   output logic      [31:0] rdata,
   output logic             ready,
   output logic             eflag
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   initial begin
      rdata = 32'h0;
      ready = 1'b0;
      eflag = 1'b0;
      cnt = 4'h0;
   end
   // data toggles outside the answer so stale data matches at most every other cycle
   always @(posedge clk) begin
      ready <= 1'b0;
      eflag <= 1'b0;
      rdata <= ~rdata;
      if (req && !ready) begin
         cnt <= cnt + 4'h1;
         if (cnt == lat) begin
            ready <= 1'b1;
            eflag <= err;
            rdata <= data;
            cnt <= 4'h0;
         end
      end
   end
endmodule : mem_model

//--- reg_file.sv
// general register file: one write port, two registered read ports
module reg_file #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 32,
   parameter int AW    = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             ce,
   // write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // read ports
   input  wire logic [AW-1:0]    raddr_a,
   output logic      [WIDTH-1:0] rdata_a,
   input  wire logic [AW-1:0]    raddr_b,
   output logic      [WIDTH-1:0] rdata_b
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // reads see the value before a write on the same edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_a <= '0;
         rdata_b <= '0;
      end else if (ce) begin
         rdata_a <= mem_q[raddr_a];
         rdata_b <= mem_q[raddr_b];
      end
   end

endmodule : reg_file

//--- shift_unit.sv
// logical shifter with carry-out for left and right shifts by 0 to 255
module shift_unit (
   // operand and count
   input  wire logic [31:0] value,
   input  wire logic [7:0]  amount,
   input  wire logic        right,
   input  wire logic        carry_in,
   // result
   output logic      [31:0] result,
   output logic             carry_out
);

   logic [63:0] left_wide;
   logic [32:0] right_wide;
   logic        beyond;

   // the extra bit on each side catches the last bit shifted out
   assign left_wide  = {32'h0, value} << amount;
   assign right_wide = {value, 1'b0} >> amount;
   assign beyond     = amount > load_shift_pkg::SHIFT_BY_32;

   assign result    = beyond ? 32'h0 :
                      (right ? right_wide[32:1] : left_wide[31:0]);           // [RULE15]
   assign carry_out = (amount == 8'h00) ? carry_in :
                      beyond ? 1'b0 :
                      (right ? right_wide[0] : left_wide[32]);                // [RULE15]

endmodule : shift_unit
